// [src/field_reg_pkg.sv]
// Purpose: constants for the dc motor field regulator
// Assumes: 100 mhz core clock, avalon-mm register access
// Notes: values are in drive units of 0..1000
`default_nettype none
package field_reg_pkg;
    // ------------------------------------------------------------
    // register word addresses (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_MAX1 = 4'h1;
    localparam logic [3:0] A_MAX2 = 4'h2;
    localparam logic [3:0] A_MINF = 4'h3;
    localparam logic [3:0] A_EMFSP = 4'h4;
    localparam logic [3:0] A_IRK = 4'h5;
    localparam logic [3:0] A_ECOTO = 4'h6;
    localparam logic [3:0] A_DIRANG = 4'h7;
    localparam logic [3:0] A_DEMAND = 4'h8;
    localparam logic [3:0] A_IFB = 4'h9;
    localparam logic [3:0] A_ANGLE = 4'ha;
    localparam logic [3:0] A_IRCOMP = 4'hb;
    localparam logic [3:0] A_EMF = 4'hc;
    localparam logic [3:0] A_STAT = 4'hd;
    localparam logic [3:0] A_TICKDIV = 4'he;
    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    localparam int B_SEL2 = 0;
    localparam int B_ECO_EN = 1;
    localparam int B_DIRECT_I = 2;
    localparam int B_DIRECT_SEL2 = 3;
    localparam int B_DIRECT_ANG = 4;
    localparam int B_IR_DEMAND = 5;
    localparam int CTRL_W = 6;
    // ------------------------------------------------------------
    // ranges and reset values
    // ------------------------------------------------------------
    localparam logic signed [17:0] V_MAX = 18'sh003e8;
    localparam logic signed [17:0] V_MIN = -18'sh003e8;
    localparam logic signed [17:0] ANG_MIN = 18'sh00105;
    localparam int IR_SHIFT = 11;
    localparam logic [10:0] RST_MAX1 = 11'h320;
    localparam logic [10:0] RST_MAX2 = 11'h1f4;
    localparam logic [10:0] RST_MINF = 11'h1f4;
    localparam logic [10:0] RST_EMFSP = 11'h3e8;
    localparam logic [10:0] RST_ANG = 11'h105;
    localparam logic [31:0] RST_ECOTO = 32'h0000_03e8;
    // control tick: time in ns and cycle count at 100 mhz
    localparam int TICK_NS = 100000;
    localparam int CLK_NS = 10;
    localparam logic [15:0] RST_TICKDIV = 16'(TICK_NS / CLK_NS);
    // loop gains as right shifts
    localparam int KV_SHIFT = 3;
    localparam int KI_SHIFT = 4;
endpackage : field_reg_pkg
`default_nettype wire

// [src/dc_motor_field_regulator.sv]
// Purpose: field regulator, emf loop, field current loop and firing angle
// Assumes: feedback inputs synchronous to core_clk_i
// Notes: all loops update once per control tick
//
// Behaviour
// - two max limits, selector picks active clamp
// - economy timer selects max2 while stopped
// - current error is demand minus feedback
// - firing angle never passes front endstop
// - direct current mode from either maximum
// - diagnostic direct firing angle bypasses loop
// - demand is emf loop output clamped
// - emf below setpoint keeps demand at max
// - emf above setpoint lowers demand
// - back emf is armature volts minus ir
// - demand readable, 0 to 1000
// - field feedback readable, 0 to 1000
// - firing angle readable, 261 to 1000
// - ir compensation signed, limited to 1000
// - ir is selected current times factor/2048
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`default_nettype none
module dc_motor_field_regulator (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic running_i,
    input wire logic sel2_pin_i,
    input wire logic signed [10:0] arm_volt_i,
    input wire logic signed [10:0] arm_ifb_i,
    input wire logic signed [10:0] arm_idem_i,
    input wire logic [10:0] field_ifb_i,
    output logic [10:0] fire_angle_o,
    output logic tick_o
);
    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    function automatic logic signed [17:0] sat(input logic signed [31:0] v,
            input logic signed [17:0] lo, input logic signed [17:0] hi);
        if (v > 32'(hi)) sat = hi;
        else if (v < 32'(lo)) sat = lo;
        else sat = v[17:0];
    endfunction : sat

    // ------------------------------------------------------------
    // register file and bus
    // ------------------------------------------------------------
    logic [field_reg_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [10:0] max1_r, max1_nxt, max2_r, max2_nxt, minf_r, minf_nxt;
    logic [10:0] emfsp_r, emfsp_nxt, irk_r, irk_nxt, dang_r, dang_nxt;
    logic [31:0] ecoto_r, ecoto_nxt;
    logic [15:0] tdiv_r, tdiv_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic [10:0] dem_r, ifb_r, ang_r;
    logic signed [17:0] ir_r, emf_r;
    logic eco_r;

    // single wait state: request taken on first cycle, answered on second
    always_comb begin
        ctrl_nxt = ctrl_r;
        max1_nxt = max1_r;
        max2_nxt = max2_r;
        minf_nxt = minf_r;
        emfsp_nxt = emfsp_r;
        irk_nxt = irk_r;
        ecoto_nxt = ecoto_r;
        dang_nxt = dang_r;
        tdiv_nxt = tdiv_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        if ((avs_read_i || avs_write_i) && wait_r) begin
            wait_nxt = 1'b0;
            if (avs_write_i && avs_byteenable_i[0]) begin
                unique case (avs_address_i)
                    field_reg_pkg::A_CTRL:
                        ctrl_nxt = avs_writedata_i[field_reg_pkg::CTRL_W-1:0];
                    field_reg_pkg::A_MAX1: max1_nxt = avs_writedata_i[10:0];
                    field_reg_pkg::A_MAX2: max2_nxt = avs_writedata_i[10:0];
                    field_reg_pkg::A_MINF: minf_nxt = avs_writedata_i[10:0];
                    field_reg_pkg::A_EMFSP: emfsp_nxt = avs_writedata_i[10:0];
                    field_reg_pkg::A_IRK: irk_nxt = avs_writedata_i[10:0];
                    field_reg_pkg::A_ECOTO: ecoto_nxt = avs_writedata_i;
                    field_reg_pkg::A_DIRANG: dang_nxt = avs_writedata_i[10:0];
                    field_reg_pkg::A_TICKDIV:
                        tdiv_nxt = avs_writedata_i[15:0];
                    default: ;
                endcase
            end
            rdata_nxt = 32'h0;
            if (avs_read_i) begin
                unique case (avs_address_i)
                    field_reg_pkg::A_CTRL: rdata_nxt = 32'(ctrl_r);
                    field_reg_pkg::A_MAX1: rdata_nxt = 32'(max1_r);
                    field_reg_pkg::A_MAX2: rdata_nxt = 32'(max2_r);
                    field_reg_pkg::A_MINF: rdata_nxt = 32'(minf_r);
                    field_reg_pkg::A_EMFSP: rdata_nxt = 32'(emfsp_r);
                    field_reg_pkg::A_IRK: rdata_nxt = 32'(irk_r);
                    field_reg_pkg::A_ECOTO: rdata_nxt = ecoto_r;
                    field_reg_pkg::A_DIRANG: rdata_nxt = 32'(dang_r);
                    field_reg_pkg::A_DEMAND: rdata_nxt = 32'(dem_r);
                    field_reg_pkg::A_IFB: rdata_nxt = 32'(ifb_r);
                    field_reg_pkg::A_ANGLE: rdata_nxt = 32'(ang_r);
                    field_reg_pkg::A_IRCOMP:
                        rdata_nxt = 32'(signed'(ir_r));
                    field_reg_pkg::A_EMF: rdata_nxt = 32'(signed'(emf_r));
                    field_reg_pkg::A_STAT: rdata_nxt = 32'(eco_r);
                    field_reg_pkg::A_TICKDIV: rdata_nxt = 32'(tdiv_r);
                    default: rdata_nxt = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= '0;
            max1_r <= field_reg_pkg::RST_MAX1;
            max2_r <= field_reg_pkg::RST_MAX2;
            minf_r <= field_reg_pkg::RST_MINF;
            emfsp_r <= field_reg_pkg::RST_EMFSP;
            irk_r <= 11'h000;
            ecoto_r <= field_reg_pkg::RST_ECOTO;
            dang_r <= field_reg_pkg::RST_ANG;
            tdiv_r <= field_reg_pkg::RST_TICKDIV;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            max1_r <= max1_nxt;
            max2_r <= max2_nxt;
            minf_r <= minf_nxt;
            emfsp_r <= emfsp_nxt;
            irk_r <= irk_nxt;
            ecoto_r <= ecoto_nxt;
            dang_r <= dang_nxt;
            tdiv_r <= tdiv_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;

    // ------------------------------------------------------------
    // control tick and economy timer
    // ------------------------------------------------------------
    logic [15:0] tcnt_r, tcnt_nxt;
    logic tick_r, tick_nxt;
    logic [31:0] eco_cnt_r, eco_cnt_nxt;
    logic eco_nxt;
    always_comb begin
        tick_nxt = (tcnt_r == 16'h0);
        tcnt_nxt = tick_nxt ? tdiv_r - 16'h1 : tcnt_r - 16'h1;
        eco_cnt_nxt = eco_cnt_r;
        eco_nxt = 1'b0;
        // counts ticks while stopped; any run clears economy at once
        if (running_i || !ctrl_r[field_reg_pkg::B_ECO_EN]) begin
            eco_cnt_nxt = 32'h0;
        end else if (eco_cnt_r >= ecoto_r) begin
            eco_nxt = 1'b1;
        end else if (tick_r) begin
            eco_cnt_nxt = eco_cnt_r + 32'h1;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tcnt_r <= 16'h0;
            tick_r <= 1'b0;
            eco_cnt_r <= 32'h0;
            eco_r <= 1'b0;
        end else begin
            tcnt_r <= tcnt_nxt;
            tick_r <= tick_nxt;
            eco_cnt_r <= eco_cnt_nxt;
            eco_r <= eco_nxt;
        end
    end
    assign tick_o = tick_r;

    // ------------------------------------------------------------
    // loops, updated on tick
    // ------------------------------------------------------------
    logic signed [17:0] vint_r, vint_nxt, iint_r, iint_nxt;
    logic signed [17:0] ir_nxt, emf_nxt, vout, verr, ierr, hi, lo;
    logic signed [17:0] dem_nxt, ang_s;
    logic signed [31:0] prod;
    logic [10:0] ang_nxt, ifb_nxt;
    logic sel2;
    always_comb begin
        // pin or software picks the limit; economy forces max2
        sel2 = ctrl_r[field_reg_pkg::B_SEL2] | sel2_pin_i | eco_r;
        hi = sel2 ? 18'(max2_r) : 18'(max1_r);
        lo = 18'(minf_r);
        prod = ctrl_r[field_reg_pkg::B_IR_DEMAND] ?
            32'(arm_idem_i) * 32'(irk_r) : 32'(arm_ifb_i) * 32'(irk_r);
        ir_nxt = sat(prod >>> field_reg_pkg::IR_SHIFT,
            field_reg_pkg::V_MIN, field_reg_pkg::V_MAX);
        emf_nxt = sat(32'(arm_volt_i) - 32'(ir_r),
            field_reg_pkg::V_MIN, field_reg_pkg::V_MAX);
        // integrator holds max while emf below setpoint, pulls down above
        verr = sat(32'(emfsp_r) - 32'(emf_r),
            field_reg_pkg::V_MIN, field_reg_pkg::V_MAX);
        vint_nxt = sat(32'(vint_r) + 32'(verr >>> field_reg_pkg::KV_SHIFT),
            lo, hi);
        vout = sat(32'(vint_nxt) + 32'(verr), lo, hi);
        if (ctrl_r[field_reg_pkg::B_DIRECT_I]) begin
            dem_nxt = ctrl_r[field_reg_pkg::B_DIRECT_SEL2] ?
                18'(max2_r) : 18'(max1_r);
        end else begin
            dem_nxt = vout;
        end
        ifb_nxt = (field_ifb_i > 11'(field_reg_pkg::V_MAX)) ?
            11'(field_reg_pkg::V_MAX) : field_ifb_i;
        ierr = sat(32'(dem_nxt) - 32'(ifb_nxt),
            field_reg_pkg::V_MIN, field_reg_pkg::V_MAX);
        iint_nxt = sat(32'(iint_r) + 32'(ierr >>> field_reg_pkg::KI_SHIFT),
            field_reg_pkg::ANG_MIN, field_reg_pkg::V_MAX);
        if (ctrl_r[field_reg_pkg::B_DIRECT_ANG]) begin
            ang_s = sat(32'(dang_r), field_reg_pkg::ANG_MIN,
                field_reg_pkg::V_MAX);
        end else begin
            ang_s = sat(32'(iint_nxt) + 32'(ierr), field_reg_pkg::ANG_MIN,
                field_reg_pkg::V_MAX);
        end
        ang_nxt = ang_s[10:0];
        if (!tick_r) begin
            ir_nxt = ir_r;
            emf_nxt = emf_r;
            vint_nxt = vint_r;
            iint_nxt = iint_r;
            dem_nxt = 18'(dem_r);
            ifb_nxt = ifb_r;
            ang_nxt = ang_r;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ir_r <= 18'sh0;
            emf_r <= 18'sh0;
            vint_r <= 18'(field_reg_pkg::RST_MAX1);
            iint_r <= field_reg_pkg::ANG_MIN;
            dem_r <= 11'h0;
            ifb_r <= 11'h0;
            ang_r <= field_reg_pkg::RST_ANG;
        end else begin
            ir_r <= ir_nxt;
            emf_r <= emf_nxt;
            vint_r <= vint_nxt;
            iint_r <= iint_nxt;
            dem_r <= dem_nxt[10:0];
            ifb_r <= ifb_nxt;
            ang_r <= ang_nxt;
        end
    end
    assign fire_angle_o = ang_r;
endmodule : dc_motor_field_regulator
`default_nettype wire

// [verification/field_bridge_model.sv]
// Purpose: behavioural thyristor field bridge and winding
// Assumes: angle 261 gives no current, 1000 gives full scale
// Notes: first-order lag, settles inside eight counts of target
`default_nettype none
module field_bridge_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [10:0] angle_i,
    output logic [10:0] ifb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // winding lag
    // ------------------------------------------------------------
    int tgt;
    int cur;
    logic [10:0] ifb_r;
    logic [10:0] ifb_nxt;
    always_comb begin
        tgt = (int'(angle_i) - 261) * 1000 / 739;
        cur = int'(ifb_r);
        ifb_nxt = 11'(cur + (tgt - cur) / 8);
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ifb_r <= 11'h000;
        end else begin
            ifb_r <= ifb_nxt;
        end
    end
    assign ifb_o = ifb_r;
endmodule : field_bridge_model
`default_nettype wire

// [verification/dc_motor_field_regulator_chk.sv]
// Purpose: port checker for the field regulator
// Assumes: one register access answered per request
// Notes: value checks only where the register range is fixed
`default_nettype none
module dc_motor_field_regulator_chk (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [10:0] fire_angle_o,
    input wire logic tick_o
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic rd_take;
    assign rd_take = avs_read_i && avs_waitrequest_o;
    angle_range_a: assert property (fire_angle_o >= 11'h105
        && fire_angle_o <= 11'h3e8) else $error("angle out of range");
    tick_pulse_a: assert property (tick_o |=> !tick_o)
        else $error("tick longer than one cycle");
    // the firing angle may only move around a tick, never between ticks
    angle_on_tick_a: assert property ($changed(fire_angle_o)
        |-> tick_o || $past(tick_o) || $past(tick_o, 2))
        else $error("angle moved without tick");
    req_answer_a: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle");
    wait_cause_a: assert property ($fell(avs_waitrequest_o)
        |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    unmapped_rd_a: assert property (rd_take && avs_address_i == 4'hf
        |=> avs_readdata_o == 32'h0) else $error("unmapped read not 0");
    demand_rd_a: assert property (rd_take && avs_address_i == 4'h8
        |=> avs_readdata_o <= 32'h3e8) else $error("demand over range");
    ifb_rd_a: assert property (rd_take && avs_address_i == 4'h9
        |=> avs_readdata_o <= 32'h3e8) else $error("feedback over range");
    irc_rd_a: assert property (rd_take && avs_address_i == 4'hb
        |=> $signed(avs_readdata_o[10:0]) >= -11'sh3e8
        && $signed(avs_readdata_o[10:0]) <= 11'sh3e8)
        else $error("ir output over range");
endmodule : dc_motor_field_regulator_chk
bind dc_motor_field_regulator dc_motor_field_regulator_chk u_chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .fire_angle_o(fire_angle_o), .tick_o(tick_o));
`default_nettype wire

// [verification/dc_motor_field_regulator_tb_top.sv]
// Purpose: self-checking bench for the field regulator
// Assumes: tick divider cut to 4 cycles after the reset check
// Notes: the bridge model closes the field current loop
`default_nettype none
module dc_motor_field_regulator_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // stimulus and tasks
    // ------------------------------------------------------------
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
    logic run = 1'b1, sel2 = 1'b0, wait_o, tick;
    logic [3:0] adr = 4'h0, be = 4'hf;
    logic [31:0] wd = 32'h0, rdat;
    logic signed [10:0] volt = 11'sh064, aifb = 11'sh0, aidem = 11'sh0;
    logic [10:0] fifb, ang;
    logic [15:0] rv;
    logic [15:0] rst_tab [8] = '{16'h0, 16'h320, 16'h1f4, 16'h1f4,
        16'h3e8, 16'h0, 16'h3e8, 16'h105};
    int error_cnt = 0, n_checks = 0;
    always #5 clk = ~clk;
    dc_motor_field_regulator dut (.core_clk_i(clk), .rstn_i(rstn),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_o), .running_i(run), .sel2_pin_i(sel2),
        .arm_volt_i(volt), .arm_ifb_i(aifb), .arm_idem_i(aidem),
        .field_ifb_i(fifb), .fire_angle_o(ang), .tick_o(tick));
    field_bridge_model bridge (.clk_i(clk), .rstn_i(rstn), .angle_i(ang),
        .ifb_o(fifb));
    task conclude;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // request held until the edge that samples waitrequest low
    task wr_b(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        adr <= a;
        wd <= d;
        be <= b;
        wr <= 1'b1;
        do @(posedge clk); while (wait_o !== 1'b0);
        wr <= 1'b0;
    endtask : wr_b
    task wrw(input logic [3:0] a, input logic [31:0] d);
        wr_b(a, d, 4'hf);
    endtask : wrw
    task rdq(input logic [3:0] a);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk); while (wait_o !== 1'b0);
        rv = rdat[15:0] & ((a == 4'he) ? 16'hffff : 16'h07ff);
        rd <= 1'b0;
    endtask : rdq
    task rdc(input logic [3:0] a, input logic [15:0] e);
        rdq(a);
        chk(rv, e);
    endtask : rdc
    task t_reset_bus;
        for (int i = 0; i < 8; i++) rdc(4'(i), rst_tab[i]);
        rdc(4'he, 16'h2710);
        wrw(4'hf, 32'h55);
        rdc(4'hf, 16'h0);
        wr_b(4'h1, 32'h1, 4'he);
        rdc(4'h1, 16'h320);
        wrw(4'he, 32'h4);
        rdc(4'he, 16'h4);
    endtask : t_reset_bus
    // the old count of the long divider runs out first: the new
    // divider only applies from the tick after it, so wait for it
    task t_tick;
        int n;
        n = 0;
        do @(posedge clk); while (tick !== 1'b1);
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
        chk(16'(n), 16'h4);
    endtask : t_tick
    task t_limits;
        cyc(400);
        rdc(4'h8, 16'h320);
        sel2 <= 1'b1;
        cyc(400);
        rdc(4'h8, 16'h1f4);
        sel2 <= 1'b0;
        wrw(4'h0, 32'h1);
        cyc(400);
        rdc(4'h8, 16'h1f4);
        wrw(4'h3, 32'h64);
        wrw(4'h4, 32'h12c);
        wrw(4'h0, 32'h0);
        volt <= 11'sh3e8;
        cyc(600);
        rdc(4'h8, 16'h64);
        wrw(4'h3, 32'h1f4);
        wrw(4'h4, 32'h3e8);
        volt <= 11'sh064;
    endtask : t_limits
    task t_direct;
        wrw(4'h0, 32'hc);
        cyc(400);
        rdc(4'h8, 16'h1f4);
        wrw(4'h0, 32'h4);
        cyc(3000);
        rdq(4'h9);
        chk(16'(rv > 16'h302 && rv < 16'h33e), 16'h1);
        wrw(4'h0, 32'h10);
        wrw(4'h7, 32'h258);
        cyc(600);
        chk({5'h0, ang}, 16'h258);
        rdc(4'ha, 16'h258);
        rdq(4'h9);
        chk(rv, {5'h0, fifb});
        wrw(4'h7, 32'h64);
        cyc(40);
        chk({5'h0, ang}, 16'h105);
        wrw(4'h7, 32'h7d0);
        cyc(40);
        rdc(4'ha, 16'h3e8);
        wrw(4'h0, 32'h0);
    endtask : t_direct
    task t_ir;
        wrw(4'h5, 32'h400);
        aifb <= 11'sh190;
        volt <= 11'sh384;
        cyc(40);
        rdc(4'hb, 16'h0c8);
        rdc(4'hc, 16'h2bc);
        wrw(4'h0, 32'h20);
        aidem <= 11'sh5a8;
        cyc(40);
        rdc(4'hb, 16'h6d4);
        wrw(4'h5, 32'h7ff);
        aidem <= 11'sh3ff;
        volt <= 11'sh418;
        cyc(40);
        rdc(4'hb, 16'h3e8);
        rdc(4'hc, 16'h418);
        wrw(4'h0, 32'h0);
        wrw(4'h5, 32'h0);
        volt <= 11'sh064;
    endtask : t_ir
    task t_eco;
        run <= 1'b0;
        wrw(4'h6, 32'h5);
        wrw(4'h0, 32'h2);
        cyc(200);
        rdc(4'hd, 16'h1);
        rdc(4'h8, 16'h1f4);
        run <= 1'b1;
        cyc(200);
        rdc(4'hd, 16'h0);
        rdc(4'h8, 16'h320);
    endtask : t_eco
    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        rstn <= 1'b1;
        cyc(4);
        t_reset_bus();
        t_tick();
        t_limits();
        t_direct();
        t_ir();
        t_eco();
        conclude();
    end
    initial begin
        #500000;
        error_cnt++;
        conclude();
    end
endmodule : dc_motor_field_regulator_tb_top
`default_nettype wire
